// file: rtl/flash_cache.sv
// flash access control, program store steering and branch target cache
// Functional notes
// - read wait code sets flash read length
// - flash write/erase only while write-enable set
// - timing reserved bits 6 and 3:1 read zero, bit 7 reads one; write zero
// - scratch select steers user flash accesses
// - scratch erase at 0x400 erases both sectors
// - erase enable plus write enable erases page
// - lock byte page never erased by software
// - data writes go external or to flash
// - 63 four-byte slots plus linear slot
// - prefetch reads four bytes per access
// - hit no stall, miss at most four
// - fill cache after miss when settings allow
// - tag is 15 upper bits plus valid
// - compare every valid tag including linear
// - stall on word being prefetched
// - no match abandons prefetch, restarts there
// - rebound victim order when algorithm zero
// - pseudo-random victim when algorithm one
// - clear strobe invalidates all entries
// - clear strobe reads back zero
// - flash write/erase evicts affected bytes
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
module flash_cache (
    input  wire logic        MCLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [9:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    input  wire logic        FETCH_REQ_IN,
    input  wire logic [16:0] FETCH_ADDR_IN,
    input  wire logic        FETCH_MOVC_IN,
    output logic             FETCH_BUSY_OUT,
    output logic             FETCH_VALID_OUT,
    output logic      [7:0]  FETCH_DATA_OUT,
    input  wire logic        CORE_WR_IN,
    input  wire logic [16:0] CORE_WR_ADDR_IN,
    input  wire logic [7:0]  CORE_WR_DATA_IN,
    output logic             XRAM_WR_OUT,
    output logic             FL_WR_OUT,
    output logic             FL_ERASE_OUT,
    output logic             FL_ERASE_BOTH_OUT,
    output logic             FL_WR_SCRATCH_OUT,
    output logic      [16:0] WR_ADDR_OUT,
    output logic      [7:0]  WR_DATA_OUT,
    output logic             FL_RD_OUT,
    output logic             FL_RD_SCRATCH_OUT,
    output logic      [14:0] FL_RADDR_OUT,
    input  wire logic [31:0] FL_RDATA_IN
);
    import flash_cache_pkg::*;

    // --------------------------------------------------------------
    // register bus
    // --------------------------------------------------------------
    logic        ack_reg;
    logic [7:0]  rdat_reg;
    logic [7:0]  rd_mux;
    logic [2:0]  psc_reg;
    logic [1:0]  rws_reg;
    logic        upe_reg;
    logic [7:0]  ccr_reg;
    logic [3:0]  ctr_reg;
    logic        wb_req;
    logic        wb_wr;
    logic [7:0]  idx;
    logic        flush_go;

    assign wb_req     = WB_CYC_IN & WB_STB_IN;
    assign wb_wr      = wb_req & WB_WE_IN & ack_reg & WB_SEL_IN[0];
    assign idx        = WB_ADR_IN[9:2];
    assign WB_ACK_OUT = ack_reg;
    assign WB_DAT_OUT = {24'h000000, rdat_reg};
    assign flush_go   = wb_wr & (idx == CCR_IDX) & WB_DAT_IN[CCR_FLSH];

    always_comb begin
        unique case (idx)
            PSC_IDX: rd_mux = {5'h00, psc_reg};
            FTC_IDX: rd_mux = FTC_RD_FIXED | {2'b00, rws_reg, 3'b000, upe_reg};
            CCR_IDX: rd_mux = ccr_reg;
            CTR_IDX: rd_mux = {4'h0, ctr_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 8'h00;
        end else begin
            ack_reg <= wb_req & ~ack_reg;
            if (wb_req & ~ack_reg) begin
                rdat_reg <= rd_mux;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            psc_reg <= PSC_RST;
            rws_reg <= RWS_RST;
            upe_reg <= UPE_RST;
            ccr_reg <= CCR_RST;
            ctr_reg <= CTR_RST;
        end else if (wb_wr) begin
            if (idx == PSC_IDX) begin
                psc_reg <= WB_DAT_IN[2:0];
            end
            if (idx == FTC_IDX) begin
                rws_reg <= WB_DAT_IN[FTC_RWS +: 2];
                upe_reg <= WB_DAT_IN[FTC_UPE];
            end
            if (idx == CCR_IDX) begin
                ccr_reg <= WB_DAT_IN[7:0] & ~(8'h01 << CCR_FLSH);
            end
            if (idx == CTR_IDX) begin
                ctr_reg <= WB_DAT_IN[3:0];
            end
        end
    end

    // --------------------------------------------------------------
    // data write steering
    // --------------------------------------------------------------
    logic scr;
    logic fl_ok;
    logic lock_hit;
    logic er_go;
    logic pg_go;
    logic inv_wr;
    logic inv_er;

    assign scr      = psc_reg[PSC_SCR];
    assign fl_ok    = CORE_WR_IN & psc_reg[PSC_PWE] & upe_reg;
    assign lock_hit = ~scr & (CORE_WR_ADDR_IN[16:10] == LOCK_PAGE);
    assign er_go    = fl_ok & psc_reg[PSC_ERS] & ~lock_hit;
    assign pg_go    = fl_ok & ~psc_reg[PSC_ERS];
    assign inv_wr   = pg_go & ~scr;
    assign inv_er   = er_go & ~scr;

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            XRAM_WR_OUT       <= 1'b0;
            FL_WR_OUT         <= 1'b0;
            FL_ERASE_OUT      <= 1'b0;
            FL_ERASE_BOTH_OUT <= 1'b0;
            FL_WR_SCRATCH_OUT <= 1'b0;
            WR_ADDR_OUT       <= 17'h00000;
            WR_DATA_OUT       <= 8'h00;
        end else begin
            XRAM_WR_OUT       <= CORE_WR_IN & ~psc_reg[PSC_PWE];
            FL_WR_OUT         <= pg_go;
            FL_ERASE_OUT      <= er_go;
            FL_ERASE_BOTH_OUT <= er_go & scr & (CORE_WR_ADDR_IN == SCR_BOTH);
            FL_WR_SCRATCH_OUT <= scr & (pg_go | er_go);
            if (CORE_WR_IN) begin
                WR_ADDR_OUT <= CORE_WR_ADDR_IN;
                WR_DATA_OUT <= CORE_WR_DATA_IN;
            end
        end
    end

    // --------------------------------------------------------------
    // tag lookup
    // --------------------------------------------------------------
    logic [14:0] tag_mem  [NSLOT];
    logic [31:0] data_mem [NSLOT];
    logic [NSLOT-1:0] valid_reg;
    logic [14:0] lin_tag_reg;
    logic [31:0] lin_data_reg;
    logic        lin_valid_reg;
    logic [14:0] f_word;
    logic        f_scr;
    logic        hit_any;
    logic [31:0] hit_data;
    logic        cache_hit;
    logic        lin_hit;
    logic        pf_match;
    logic [31:0] hit_word;

    assign f_word = FETCH_ADDR_IN[16:2];
    assign f_scr  = FETCH_MOVC_IN & scr;

    always_comb begin
        hit_any  = 1'b0;
        hit_data = 32'h00000000;
        for (int i = 0; i < NSLOT; i++) begin
            if (valid_reg[i] && tag_mem[i] == f_word) begin
                hit_any  = 1'b1;
                hit_data = data_mem[i];
            end
        end
    end

    // --------------------------------------------------------------
    // prefetch engine
    // --------------------------------------------------------------
    logic        pf_busy_reg;
    logic        pf_scr_reg;
    logic [14:0] pf_word_reg;
    logic [1:0]  pf_cnt_reg;
    logic        pend_reg;
    logic [16:0] pend_addr_reg;
    logic        pend_movc_reg;
    logic        pend_scr_reg;
    logic        take;
    logic        start_new;
    logic        restart;
    logic        pf_done;
    logic        serve;
    logic        fill;

    assign cache_hit = ccr_reg[CCR_RDEN] & hit_any & ~f_scr;
    assign lin_hit   = lin_valid_reg & (lin_tag_reg == f_word) & ~f_scr;
    assign pf_match  = pf_busy_reg & (pf_scr_reg == f_scr) & (pf_word_reg == f_word);
    assign hit_word  = cache_hit ? hit_data : lin_data_reg;
    assign take      = FETCH_REQ_IN & ~pend_reg;
    assign start_new = take & ~cache_hit & ~lin_hit & ~pf_match;
    assign restart   = pf_busy_reg & (flush_go | inv_wr | inv_er);
    assign pf_done   = pf_busy_reg & (pf_cnt_reg == 2'd0) & ~restart;
    assign serve     = pend_reg & pf_done & (pf_scr_reg == pend_scr_reg)
                     & (pf_word_reg == pend_addr_reg[16:2]);
    assign fill      = serve & ~pend_scr_reg & ccr_reg[CCR_WREN]
                     & (~pend_movc_reg | ccr_reg[CCR_MOVC]);

    assign FL_RD_OUT         = pf_busy_reg;
    assign FL_RD_SCRATCH_OUT = pf_scr_reg;
    assign FL_RADDR_OUT      = pf_word_reg;
    assign FETCH_BUSY_OUT    = pend_reg;

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            pf_busy_reg <= 1'b0;
            pf_scr_reg  <= 1'b0;
            pf_word_reg <= 15'h0000;
            pf_cnt_reg  <= 2'd0;
        end else if (start_new) begin
            pf_busy_reg <= 1'b1;
            pf_scr_reg  <= f_scr;
            pf_word_reg <= f_word;
            pf_cnt_reg  <= rws_reg;
        end else if (restart) begin
            pf_cnt_reg <= rws_reg;
        end else if (pf_done) begin
            if (ccr_reg[CCR_PFEN] & ~pf_scr_reg) begin
                pf_word_reg <= pf_word_reg + 15'd1;
                pf_cnt_reg  <= rws_reg;
            end else begin
                pf_busy_reg <= 1'b0;
            end
        end else if (pf_busy_reg) begin
            pf_cnt_reg <= pf_cnt_reg - 2'd1;
        end
    end

    // --------------------------------------------------------------
    // core fetch answer
    // --------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            pend_reg        <= 1'b0;
            pend_addr_reg   <= 17'h00000;
            pend_movc_reg   <= 1'b0;
            pend_scr_reg    <= 1'b0;
            FETCH_VALID_OUT <= 1'b0;
            FETCH_DATA_OUT  <= 8'h00;
        end else begin
            FETCH_VALID_OUT <= 1'b0;
            if (take & (cache_hit | lin_hit)) begin
                FETCH_VALID_OUT <= 1'b1;
                FETCH_DATA_OUT  <= hit_word[8*FETCH_ADDR_IN[1:0] +: 8];
            end else if (take & pf_match & pf_done) begin
                FETCH_VALID_OUT <= 1'b1;
                FETCH_DATA_OUT  <= FL_RDATA_IN[8*FETCH_ADDR_IN[1:0] +: 8];
            end else if (take) begin
                pend_reg      <= 1'b1;
                pend_addr_reg <= FETCH_ADDR_IN;
                pend_movc_reg <= FETCH_MOVC_IN;
                pend_scr_reg  <= f_scr;
            end else if (serve) begin
                pend_reg        <= 1'b0;
                FETCH_VALID_OUT <= 1'b1;
                FETCH_DATA_OUT  <= FL_RDATA_IN[8*pend_addr_reg[1:0] +: 8];
            end
        end
    end

    // --------------------------------------------------------------
    // victim selection
    // --------------------------------------------------------------
    logic [5:0] lfsr_reg;
    logic [5:0] rb_ptr_reg;
    rb_dir_t    rb_dir_reg;
    logic [5:0] victim;

    assign victim = ctr_reg[CTR_ALG] ? lfsr_reg - 6'd1 : rb_ptr_reg;

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            lfsr_reg <= LFSR_SEED;
        end else begin
            lfsr_reg <= {lfsr_reg[4:0], lfsr_reg[5] ^ lfsr_reg[4]};
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            rb_ptr_reg <= 6'd0;
            rb_dir_reg <= RB_UP;
        end else if (fill & ~ctr_reg[CTR_ALG]) begin
            unique case (rb_dir_reg)
                RB_UP: begin
                    if (rb_ptr_reg == LAST_SLOT) begin
                        rb_ptr_reg <= LAST_SLOT - 6'd1;
                        rb_dir_reg <= RB_DOWN;
                    end else begin
                        rb_ptr_reg <= rb_ptr_reg + 6'd1;
                    end
                end
                RB_DOWN: begin
                    if (rb_ptr_reg == 6'd0) begin
                        rb_ptr_reg <= 6'd1;
                        rb_dir_reg <= RB_UP;
                    end else begin
                        rb_ptr_reg <= rb_ptr_reg - 6'd1;
                    end
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // cache storage
    // --------------------------------------------------------------
    always_ff @(posedge MCLK_IN) begin
        if (fill) begin
            tag_mem[victim]  <= pf_word_reg;
            data_mem[victim] <= FL_RDATA_IN;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            valid_reg <= '0;
        end else begin
            for (int i = 0; i < NSLOT; i++) begin
                if (fill && victim == 6'(i)) begin
                    valid_reg[i] <= 1'b1;
                end
                if (flush_go) begin
                    valid_reg[i] <= 1'b0;
                end
                if (inv_wr && tag_mem[i] == CORE_WR_ADDR_IN[16:2]) begin
                    valid_reg[i] <= 1'b0;
                end
                if (inv_er && tag_mem[i][14:8] == CORE_WR_ADDR_IN[16:10]) begin
                    valid_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            lin_valid_reg <= 1'b0;
            lin_tag_reg   <= 15'h0000;
            lin_data_reg  <= 32'h00000000;
        end else if (flush_go | inv_wr | inv_er) begin
            lin_valid_reg <= 1'b0;
        end else if (pf_done & ~pf_scr_reg) begin
            lin_valid_reg <= 1'b1;
            lin_tag_reg   <= pf_word_reg;
            lin_data_reg  <= FL_RDATA_IN;
        end
    end

endmodule

// file: rtl/flash_cache_pkg.sv
// constants and types of the flash access path and branch target cache
package flash_cache_pkg;

    // --------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // --------------------------------------------------------------
    localparam logic [7:0] PSC_IDX = 8'h8f;
    localparam logic [7:0] FTC_IDX = 8'hb7;
    localparam logic [7:0] CCR_IDX = 8'ha1;
    localparam logic [7:0] CTR_IDX = 8'ha2;

    // --------------------------------------------------------------
    // reset values and fixed read bits
    // --------------------------------------------------------------
    localparam logic [2:0] PSC_RST      = 3'h0;
    localparam logic [7:0] FTC_RD_FIXED = 8'h80;
    localparam logic [1:0] RWS_RST      = 2'h0;
    localparam logic       UPE_RST      = 1'b0;
    localparam logic [7:0] CCR_RST      = 8'he6;
    localparam logic [3:0] CTR_RST      = 4'h4;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int PSC_SCR  = 2;
    localparam int PSC_ERS  = 1;
    localparam int PSC_PWE  = 0;
    localparam int FTC_RWS  = 4;
    localparam int FTC_UPE  = 0;
    localparam int CCR_WREN = 7;
    localparam int CCR_RDEN = 6;
    localparam int CCR_PFEN = 5;
    localparam int CCR_FLSH = 4;
    localparam int CCR_MOVC = 1;
    localparam int CTR_ALG  = 3;

    // --------------------------------------------------------------
    // cache geometry and flash map
    // --------------------------------------------------------------
    localparam int              NSLOT     = 63;
    localparam logic [5:0]      LAST_SLOT = 6'd62;
    localparam logic [5:0]      LFSR_SEED = 6'h01;
    localparam logic [6:0]      LOCK_PAGE = 7'h7f;
    localparam logic [16:0]     SCR_BOTH  = 17'h00400;

    typedef enum logic {RB_DOWN, RB_UP} rb_dir_t;

endpackage

// file: tb/flash_array_model.sv
// behavioural flash array answering word reads of the cache
`timescale 1ns/1ns
module flash_array_model (
    input  wire logic        clk_in,
    input  wire logic        rd_in,
    input  wire logic [14:0] raddr_in,
    output logic      [31:0] rdata_out
);
    logic [31:0] last_reg = 32'h0;
    function automatic logic [31:0] word_of(input logic [14:0] w);
        return {w[7:0] ^ 8'h96, w[7:0] ^ 8'h69, w[7:0] ^ 8'hc3, w[7:0]};
    endfunction
    // released bus shows the inverse of its own value one cycle earlier
    always_ff @(posedge clk_in) begin
        last_reg <= rdata_out;
    end
    // four bytes a word, held for the whole read whatever its length
    assign rdata_out = rd_in ? word_of(raddr_in) : ~last_reg;
endmodule

// file: tb/flash_cache_props.sv
// assertions on the ports of the flash access path
`timescale 1ns/1ns
module flash_cache_props (
    input wire logic        MCLK_IN,
    input wire logic        NRST_IN,
    input wire logic        WB_CYC_IN,
    input wire logic        WB_STB_IN,
    input wire logic        WB_WE_IN,
    input wire logic [9:0]  WB_ADR_IN,
    input wire logic [3:0]  WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic        WB_ACK_OUT,
    input wire logic        FETCH_REQ_IN,
    input wire logic        FETCH_BUSY_OUT,
    input wire logic        FETCH_VALID_OUT,
    input wire logic        CORE_WR_IN,
    input wire logic [16:0] CORE_WR_ADDR_IN,
    input wire logic        XRAM_WR_OUT,
    input wire logic        FL_WR_OUT,
    input wire logic        FL_ERASE_OUT,
    input wire logic        FL_ERASE_BOTH_OUT,
    input wire logic        FL_WR_SCRATCH_OUT
);
    import flash_cache_pkg::*;
    logic [2:0] psc_reg;
    logic       upe_reg;
    logic       wr_acc;
    logic       prog_ok;
    logic       lock_pg;
    assign wr_acc = WB_ACK_OUT && WB_CYC_IN && WB_STB_IN && WB_WE_IN && WB_SEL_IN[0];
    assign prog_ok = CORE_WR_IN && upe_reg && psc_reg[PSC_PWE];
    assign lock_pg = CORE_WR_ADDR_IN[16:10] == LOCK_PAGE;
    // shadow of the write steering bits
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            psc_reg <= PSC_RST;
        end else if (wr_acc && WB_ADR_IN[9:2] == PSC_IDX) begin
            psc_reg <= WB_DAT_IN[2:0];
        end
    end
    always_ff @(posedge MCLK_IN) begin
        if (!NRST_IN) begin
            upe_reg <= UPE_RST;
        end else if (wr_acc && WB_ADR_IN[9:2] == FTC_IDX) begin
            upe_reg <= WB_DAT_IN[FTC_UPE];
        end
    end
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!NRST_IN);
    sequence s_take;
        FETCH_REQ_IN && !FETCH_BUSY_OUT;
    endsequence
    sequence s_rd(logic [7:0] idx);
        WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN[9:2] == idx;
    endsequence
    chk_ack_pulse: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
        |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
        else $error("register ack is not a one cycle answer");
    chk_ftc_zeros: assert property (s_rd(FTC_IDX) |-> WB_DAT_OUT[7:6] == 2'h2
        && WB_DAT_OUT[3:1] == 3'h0)
        else $error("timing register fixed bits wrong");
    chk_flush_zero: assert property (s_rd(CCR_IDX) |-> !WB_DAT_OUT[CCR_FLSH])
        else $error("clear strobe reads one");
    chk_locked_drop: assert property (CORE_WR_IN && !upe_reg |=> !FL_WR_OUT && !FL_ERASE_OUT)
        else $error("flash changed while writes disabled");
    chk_xram_route: assert property (CORE_WR_IN && !psc_reg[PSC_PWE]
        |=> XRAM_WR_OUT && !FL_WR_OUT)
        else $error("data write not sent to external ram");
    chk_flash_byte: assert property (prog_ok && !psc_reg[PSC_ERS]
        |=> FL_WR_OUT && !XRAM_WR_OUT)
        else $error("data write not sent to flash");
    chk_page_erase: assert property (prog_ok && psc_reg[PSC_ERS]
        && !psc_reg[PSC_SCR] && !lock_pg |=> FL_ERASE_OUT && !FL_WR_OUT)
        else $error("page erase missing");
    chk_lock_page: assert property (CORE_WR_IN && lock_pg
        && !psc_reg[PSC_SCR] |=> !FL_ERASE_OUT)
        else $error("lock byte page erased");
    chk_scratch_both: assert property (prog_ok && psc_reg[PSC_ERS]
        && psc_reg[PSC_SCR] && CORE_WR_ADDR_IN == SCR_BOTH
        |=> FL_ERASE_BOTH_OUT && FL_WR_SCRATCH_OUT)
        else $error("scratch double erase missing");
    chk_fetch_bound: assert property (s_take |-> ##[1:5] FETCH_VALID_OUT)
        else $error("fetch answer later than four stall cycles");
    chk_busy_end: assert property ($fell(FETCH_BUSY_OUT) |-> FETCH_VALID_OUT)
        else $error("stall ended without data");
endmodule
bind flash_cache flash_cache_props i_flash_cache_props (
    .MCLK_IN(MCLK_IN), .NRST_IN(NRST_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
    .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .FETCH_REQ_IN(FETCH_REQ_IN),
    .FETCH_BUSY_OUT(FETCH_BUSY_OUT), .FETCH_VALID_OUT(FETCH_VALID_OUT), .CORE_WR_IN(CORE_WR_IN),
    .CORE_WR_ADDR_IN(CORE_WR_ADDR_IN), .XRAM_WR_OUT(XRAM_WR_OUT), .FL_WR_OUT(FL_WR_OUT),
    .FL_ERASE_OUT(FL_ERASE_OUT), .FL_ERASE_BOTH_OUT(FL_ERASE_BOTH_OUT),
    .FL_WR_SCRATCH_OUT(FL_WR_SCRATCH_OUT)
);

// file: tb/flash_cache_test.sv
// self-checking bench of the flash access path and branch target cache
`timescale 1ns/1ns
module flash_cache_test;
    import flash_cache_pkg::*;
    logic        mclk_in = 1'h0, nrst_in = 1'h0, wb_cyc_in = 1'h0, wb_stb_in = 1'h0;
    logic        wb_we_in = 1'h0, fetch_req_in = 1'h0, fetch_movc_in = 1'h0, core_wr_in = 1'h0;
    logic [9:0]  wb_adr_in = 10'h0;
    logic [3:0]  wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, fl_rdata_in, rdq;
    logic [16:0] fetch_addr_in = 17'h0, core_wr_addr_in = 17'h0, wr_addr_out;
    logic [7:0]  core_wr_data_in = 8'h0, fetch_data_out, wr_data_out;
    logic        wb_ack_out, fetch_busy_out, fetch_valid_out, xram_wr_out, fl_wr_out;
    logic        fl_erase_out, fl_erase_both_out, fl_wr_scratch_out, fl_rd_out, fl_rd_scratch_out;
    logic [14:0] fl_raddr_out;
    int          errors = 0, compares = 0;
    flash_cache i_flash_cache (
        .MCLK_IN(mclk_in), .NRST_IN(nrst_in), .WB_CYC_IN(wb_cyc_in), .WB_STB_IN(wb_stb_in),
        .WB_WE_IN(wb_we_in), .WB_ADR_IN(wb_adr_in), .WB_SEL_IN(wb_sel_in), .WB_DAT_IN(wb_dat_in),
        .WB_DAT_OUT(wb_dat_out), .WB_ACK_OUT(wb_ack_out), .FETCH_REQ_IN(fetch_req_in),
        .FETCH_ADDR_IN(fetch_addr_in), .FETCH_MOVC_IN(fetch_movc_in),
        .FETCH_BUSY_OUT(fetch_busy_out), .FETCH_VALID_OUT(fetch_valid_out),
        .FETCH_DATA_OUT(fetch_data_out), .CORE_WR_IN(core_wr_in),
        .CORE_WR_ADDR_IN(core_wr_addr_in),
        .CORE_WR_DATA_IN(core_wr_data_in), .XRAM_WR_OUT(xram_wr_out), .FL_WR_OUT(fl_wr_out),
        .FL_ERASE_OUT(fl_erase_out), .FL_ERASE_BOTH_OUT(fl_erase_both_out),
        .FL_WR_SCRATCH_OUT(fl_wr_scratch_out), .WR_ADDR_OUT(wr_addr_out),
        .WR_DATA_OUT(wr_data_out), .FL_RD_OUT(fl_rd_out), .FL_RD_SCRATCH_OUT(fl_rd_scratch_out),
        .FL_RADDR_OUT(fl_raddr_out), .FL_RDATA_IN(fl_rdata_in)
    );
    flash_array_model i_flash_array_model (
        .clk_in(mclk_in), .rd_in(fl_rd_out), .raddr_in(fl_raddr_out), .rdata_out(fl_rdata_in)
    );
    initial begin
        forever #4 mclk_in = ~mclk_in;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        wb_cyc_in <= 1'h1;
        wb_stb_in <= 1'h1;
        wb_we_in <= we;
        wb_adr_in <= {idx, 2'h0};
        wb_sel_in <= 4'h1;
        wb_dat_in <= {24'h0, d};
        @(posedge mclk_in);
        while (wb_ack_out !== 1'h1) begin
            @(posedge mclk_in);
        end
        rdq = wb_dat_out;
        wb_cyc_in <= 1'h0;
        wb_stb_in <= 1'h0;
        @(posedge mclk_in);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'h1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        wb(1'h0, idx, 8'h0);
        check("reg_read", {24'h0, e}, rdq);
    endtask
    task automatic cw(input logic [16:0] a, input logic [4:0] e);
        core_wr_in <= 1'h1;
        core_wr_addr_in <= a;
        core_wr_data_in <= 8'h5a;
        @(posedge mclk_in);
        core_wr_in <= 1'h0;
        @(posedge mclk_in);
        check("route", {27'h0, e}, {27'h0, xram_wr_out, fl_wr_out, fl_erase_out,
            fl_erase_both_out, fl_wr_scratch_out});
        check("wr_bus", {7'h0, a, 8'h5a}, {7'h0, wr_addr_out, wr_data_out});
    endtask
    task automatic fetch(input logic [16:0] a, input int lo, input int hi);
        int          n;
        logic [31:0] km;
        n = 1;
        km = 32'h9669c300;
        fetch_req_in <= 1'h1;
        fetch_addr_in <= a;
        @(posedge mclk_in);
        fetch_req_in <= 1'h0;
        @(posedge mclk_in);
        while (fetch_valid_out !== 1'h1 && n < 20) begin
            @(posedge mclk_in);
            n++;
        end
        check("latency_ok", 32'h1, {31'h0, n >= lo && n <= hi});
        check("fetch_data", {24'h0, a[9:2] ^ km[8 * a[1:0] +: 8]}, {24'h0, fetch_data_out});
    endtask
    task automatic t_regs;
        rd(PSC_IDX, 8'h00);
        rd(FTC_IDX, 8'h80);
        rd(CCR_IDX, 8'he6);
        rd(CTR_IDX, 8'h04);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
        wr(FTC_IDX, 8'hff);
        rd(FTC_IDX, 8'hb1);
        wr(CCR_IDX, 8'hf6);
        rd(CCR_IDX, 8'he6);
        wr(CTR_IDX, 8'hff);
        rd(CTR_IDX, 8'h0f);
        wr(CTR_IDX, 8'h04);
        wr(PSC_IDX, 8'hff);
        rd(PSC_IDX, 8'h07);
        wr(PSC_IDX, 8'h00);
    endtask
    task automatic t_fetch;
        wr(CCR_IDX, 8'h06);
        for (int r = 0; r < 4; r++) begin
            wr(FTC_IDX, {2'h0, r[1:0], 4'h0});
            wr(CCR_IDX, 8'hf6);
            fetch(17'h00105, r + 2, r + 2);
            fetch(17'h00105, 1, 1);
            fetch(17'h0010a, 1, r + 2);
            fetch(17'h01003, r + 2, r + 2);
        end
    endtask
    task automatic t_evict;
        fetch(17'h00105, 1, 1);
        wr(FTC_IDX, 8'h31);
        wr(PSC_IDX, 8'h01);
        cw(17'h00106, 5'b01000);
        wr(PSC_IDX, 8'h00);
        wr(CTR_IDX, 8'h0c);
        fetch(17'h00105, 2, 5);
        repeat (4) @(posedge mclk_in);
        fetch(17'h00105, 1, 1);
    endtask
    task automatic t_route;
        cw(17'h00200, 5'b10000);
        wr(FTC_IDX, 8'h30);
        wr(PSC_IDX, 8'h03);
        cw(17'h00200, 5'b00000);
        wr(FTC_IDX, 8'h31);
        cw(17'h00200, 5'b00100);
        cw(17'h1fc00, 5'b00000);
        wr(PSC_IDX, 8'h07);
        cw(17'h00400, 5'b00111);
        wr(PSC_IDX, 8'h05);
        cw(17'h00010, 5'b01001);
        fetch_movc_in <= 1'h1;
        fetch(17'h00010, 2, 5);
        check("rd_scratch", 32'h1, {31'h0, fl_rd_scratch_out});
        fetch_movc_in <= 1'h0;
    endtask
    task automatic summarize;
        if (errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk_in);
        nrst_in <= 1'h1;
        @(posedge mclk_in);
        t_regs;
        t_fetch;
        t_evict;
        t_route;
        summarize;
    end
    initial begin
        repeat (5000) @(posedge mclk_in);
        errors++;
        $display("Error watchdog expected done seen timeout");
        summarize;
    end
endmodule
